// *** crypto_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module crypto_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            wr;
  wire            rd;
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  assign wr = ce & in_valid & in_ready;
  assign rd = ce & out_valid & out_ready;
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (wr)
      begin
        mem[wp_q] <= in_data;
        wp_q      <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd)
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (wr & ~rd)
        cnt_q <= cnt_q + 1'b1;
      else if (rd & ~wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // crypto_fifo
`default_nettype wire

// *** crypto_flow_chk_sva.sv ***
// Port-level assertions for the crypto port packet flow block
`timescale 1ns/10ps
`default_nettype none
`include "crypto_flow_defines.vh"
module crypto_flow_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        req_valid,
  input wire logic        redirect_to_cipher_flag,
  input wire logic [14:0] pkt_len,
  input wire logic        buf_space_ok,
  input wire logic        cfg_drop,
  input wire logic        lfsr_wr,
  input wire logic [31:0] lfsr_wdata,
  input wire logic        reinject_ready,
  input wire logic        tx_port_valid,
  input wire logic [3:0]  tx_egress_port,
  input wire logic        reinject_valid,
  input wire logic [3:0]  reinject_src_port,
  input wire logic [10:0] reinject_dest_ports,
  input wire logic [2:0]  reinject_queue,
  input wire logic        reinject_second_pass,
  input wire logic        encrypted_flag,
  input wire logic [1:0]  hdr_insert,
  input wire logic [1:0]  hdr_remove,
  input wire logic [31:0] lfsr_rdata,
  input wire logic        drop_pulse,
  input wire logic        to_cpu_pulse,
  input wire logic [2:0]  cpu_reason,
  input wire logic [15:0] size_drop_count,
  input wire logic [15:0] buffer_drop_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire tk  = ce && req_valid && redirect_to_cipher_flag;
  wire lok = pkt_len <= `CF_LEN_MAX && pkt_len >= `CF_LEN_MIN;
  port_number_a: assert property (tx_port_valid |-> tx_egress_port == `CF_CRYPTO_PORT)
    else $error("crypto port number wrong");
  size_drop_a: assert property (tk && !lok |=> drop_pulse && !tx_port_valid
    && size_drop_count == $past(size_drop_count) + 16'h1) else $error("size drop missed");
  buffer_drop_a: assert property (tk && lok && !buf_space_ok |=> drop_pulse
    && buffer_drop_count == $past(buffer_drop_count) + 16'h1 && $stable(size_drop_count))
    else $error("buffer drop missed");
  size_count_a: assert property ($changed(size_drop_count) |-> drop_pulse)
    else $error("size count moved without drop");
  context_hold_a: assert property (ce && reinject_valid && !reinject_ready |=>
    reinject_valid && $stable({reinject_src_port, reinject_dest_ports, reinject_queue}))
    else $error("reinject context not held");
  second_pass_a: assert property (reinject_valid |-> reinject_second_pass)
    else $error("second pass not marked");
  enc_header_a: assert property (reinject_valid && encrypted_flag |-> hdr_insert != 2'h3
    && hdr_remove == 2'h3) else $error("encrypt header edit wrong");
  dec_header_a: assert property (reinject_valid && hdr_remove != 2'h3 |-> !encrypted_flag
    && hdr_insert == 2'h3) else $error("decrypt header edit wrong");
  cpu_event_a: assert property (to_cpu_pulse |-> !$past(cfg_drop) && !drop_pulse
    && cpu_reason != 3'h0) else $error("cpu event wrong");
  lfsr_load_a: assert property (ce && lfsr_wr |-> ##2 lfsr_rdata == $past(lfsr_wdata, 2))
    else $error("lfsr load lost");
endmodule // crypto_flow_chk
bind packet_crypto_port_flow crypto_flow_chk chk (.*);
`default_nettype wire

// *** crypto_flow_defines.vh ***
// Constants for the crypto port packet flow block
`ifndef CRYPTO_FLOW_DEFINES_VH
`define CRYPTO_FLOW_DEFINES_VH
`define CF_CRYPTO_PORT      4'hb
`define CF_LEN_MAX          15'h4003
`define CF_LEN_MIN          15'h003c
`define CF_REPLAY_WIN       8'h80
`define CF_SA_W             4
`define CF_SA_N             16
`define CF_OP_ENC           1'b0
`define CF_OP_DEC           1'b1
`define CF_PROTO_AH         2'h0
`define CF_PROTO_ESP        2'h1
`define CF_PROTO_MACSEC     2'h2
`define CF_LFSR_SEED        32'h0000_0001
`define CF_LFSR_TAPS        32'h8020_0003
`define CF_RSN_NO_SA        3'h1
`define CF_RSN_FRAG         3'h2
`define CF_RSN_SEQ_OVF      3'h3
`define CF_RSN_REPLAY       3'h4
`define CF_RSN_ICV          3'h5
`define CF_FIFO_DEPTH       4
`endif

// *** packet_crypto_port_flow.v ***
// Admission, header edit control and replay checking around the crypto port
`timescale 1ns/10ps
`default_nettype none
`include "crypto_flow_defines.vh"
// How it works
// - Crypto work is sent to internal port eleven.
// - Crypto port gets the normal eight queues with ordinary scheduling.
// - Processed packets go back through ingress and egress a second time.
// - Each association entry is either encrypt or decrypt, never both.
// - Per association, keep highest seen or last generated sequence number.
// - Redirect flag sends packet; index picks association, operation field picks op.
// - Protocol from ACL select field, or IPSec table field for next hop.
// - Queue, destination ports and source port travel with the packet.
// - Drop the packet when buffer space is insufficient.
// - Drop lengths over 16387 or under 60 bytes and count them.
// - AH encrypt inserts header, edits IP header, IPv4 checksum redone.
// - ESP encrypt inserts header, edits IP header, IPv4 checksum redone.
// - MACsec header inserted after the configured number of VLAN tags.
// - IV comes from an LFSR stepped per AH/ESP encrypted packet, software accessible.
// - Re-inject with original source port, destinations and queue.
// - After encryption flag it and give the association index to ACLs.
// - AH/ESP decrypt strips header, restores L4 type, redoes IPv4 checksum.
// - MACsec decrypt strips header so original Ethernet type shows.
// - Decrypt runs replay check; failures dropped or sent to CPU.
// - IPSec keeps a 128-entry seen bitmap below the highest number; a new highest number resets it to that number's bit alone.
// - MACsec rejects numbers below highest minus programmable window.
// - Encrypted queue fields mean queue selection waits until after decryption.
// - Global drop setting picks discard or CPU for each special event.
module packet_crypto_port_flow (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        ce,
  // Pre-crypto request
  input  wire        req_valid,
  input  wire        redirect_to_cipher_flag,
  input  wire        from_acl,
  input  wire [3:0]  security_assoc_index,
  input  wire        cipher_operation_select,
  input  wire [1:0]  encap_protocol_select,
  input  wire [1:0]  ipsec_table_protocol,
  input  wire [2:0]  dest_queue,
  input  wire [10:0] dest_ports,
  input  wire [3:0]  src_port,
  input  wire [14:0] pkt_len,
  input  wire        is_ipv4,
  input  wire        is_fragment,
  input  wire        sa_hit,
  input  wire        queue_fields_encrypted,
  input  wire        buf_space_ok,
  input  wire [31:0] seq_num,
  // Configuration
  input  wire        cfg_drop,
  input  wire [1:0]  cfg_macsec_vlans,
  input  wire [31:0] cfg_macsec_window,
  input  wire        lfsr_wr,
  input  wire [31:0] lfsr_wdata,
  // Engine end
  input  wire        icv_fail,
  input  wire        reinject_ready,
  // Outputs
  output reg         tx_port_valid,
  output reg  [3:0]  tx_egress_port,
  output reg         reinject_valid,
  output reg  [3:0]  reinject_src_port,
  output reg  [10:0] reinject_dest_ports,
  output reg  [2:0]  reinject_queue,
  output reg         reinject_defer_queue,
  output reg         reinject_second_pass,
  output reg         encrypted_flag,
  output reg  [3:0]  encrypted_sa_index,
  output reg  [1:0]  hdr_insert,
  output reg  [1:0]  hdr_remove,
  output reg  [1:0]  hdr_vlan_skip,
  output reg         hdr_ipv4_csum,
  output reg         hdr_restore_l4,
  output reg  [31:0] iv_value,
  output reg  [31:0] lfsr_rdata,
  output reg         drop_pulse,
  output reg         to_cpu_pulse,
  output reg  [2:0]  cpu_reason,
  output reg  [15:0] size_drop_count,
  output reg  [15:0] buffer_drop_count
);
  localparam FW = 1 + 4 + 2 + 3 + 11 + 4 + 1 + 1 + 32 + 1 + 1 + 1;
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  reg  [31:0]  lfsr_q;
  reg  [31:0]  seq_q   [0:`CF_SA_N-1];
  reg  [127:0] seen_q  [0:`CF_SA_N-1];
  reg  [1:0]   state_q;
  wire         accept;
  wire         len_bad;
  wire [1:0]   proto;
  wire [FW-1:0] f_in;
  wire [FW-1:0] f_out;
  wire         f_valid;
  wire         f_ready;
  wire         f_in_ready;
  wire         o_op;
  wire [3:0]   o_sa;
  wire [1:0]   o_pr;
  wire [2:0]   o_q;
  wire [10:0]  o_dp;
  wire [3:0]   o_sp;
  wire         o_v4;
  wire         o_defer;
  wire [31:0]  o_seq;
  wire         o_frag;
  wire         o_hit;
  wire         o_fat;
  wire [31:0]  hi;
  wire [127:0] bm;
  wire [31:0]  diff;
  reg          replay_bad;
  reg  [2:0]   rsn;

  assign proto   = from_acl ? encap_protocol_select : ipsec_table_protocol;
  assign len_bad = (pkt_len > `CF_LEN_MAX) || (pkt_len < `CF_LEN_MIN);
  assign accept  = req_valid & redirect_to_cipher_flag & buf_space_ok & ~len_bad;
  // Context carried through the engine alongside the packet
  assign f_in = {cipher_operation_select, security_assoc_index, proto, dest_queue, dest_ports,
                 src_port, is_ipv4, queue_fields_encrypted, seq_num, is_fragment, sa_hit,
                 1'b0};
  assign {o_op, o_sa, o_pr, o_q, o_dp, o_sp, o_v4, o_defer, o_seq, o_frag, o_hit, o_fat} = f_out;

  // Egress stalls push back to the queue; requests are dropped only once it is full
  crypto_fifo #(.WIDTH(FW), .DEPTH(`CF_FIFO_DEPTH), .AW(2)) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .ce        (ce),
    .in_data   (f_in),
    .in_valid  (accept),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
  assign f_ready = (state_q == ST_IDLE);

  assign hi   = seq_q[o_sa];
  assign bm   = seen_q[o_sa];
  assign diff = hi - o_seq;

  always @*
  begin
    replay_bad = 1'b0;
    if (o_pr == `CF_PROTO_MACSEC)
      replay_bad = (o_seq < hi) && (diff > cfg_macsec_window);
    else if (o_seq <= hi)
      replay_bad = (diff >= {24'h0, `CF_REPLAY_WIN}) || bm[diff[6:0]];
    rsn = 3'h0;
    if (!o_hit)
      rsn = `CF_RSN_NO_SA;
    else if (o_frag & (o_pr != `CF_PROTO_MACSEC))
      rsn = `CF_RSN_FRAG;
    else if ((o_op == `CF_OP_ENC) && (hi == 32'hffff_ffff))
      rsn = `CF_RSN_SEQ_OVF;
    else if ((o_op == `CF_OP_DEC) && replay_bad)
      rsn = `CF_RSN_REPLAY;
    else if ((o_op == `CF_OP_DEC) && icv_fail)
      rsn = `CF_RSN_ICV;
  end

  integer i;
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q              <= ST_IDLE;
      lfsr_q               <= `CF_LFSR_SEED;
      tx_port_valid        <= 1'b0;
      tx_egress_port       <= 4'h0;
      reinject_valid       <= 1'b0;
      reinject_src_port    <= 4'h0;
      reinject_dest_ports  <= 11'h000;
      reinject_queue       <= 3'h0;
      reinject_defer_queue <= 1'b0;
      reinject_second_pass <= 1'b0;
      encrypted_flag       <= 1'b0;
      encrypted_sa_index   <= 4'h0;
      hdr_insert           <= 2'h0;
      hdr_remove           <= 2'h0;
      hdr_vlan_skip        <= 2'h0;
      hdr_ipv4_csum        <= 1'b0;
      hdr_restore_l4       <= 1'b0;
      iv_value             <= 32'h0;
      lfsr_rdata           <= `CF_LFSR_SEED;
      drop_pulse           <= 1'b0;
      to_cpu_pulse         <= 1'b0;
      cpu_reason           <= 3'h0;
      size_drop_count      <= 16'h0;
      buffer_drop_count    <= 16'h0;
      for (i = 0; i < `CF_SA_N; i = i + 1)
      begin
        seq_q[i]  <= 32'h0;
        seen_q[i] <= 128'h0;
      end
    end
    else if (ce)
    begin
      drop_pulse    <= 1'b0;
      to_cpu_pulse  <= 1'b0;
      tx_port_valid <= 1'b0;
      lfsr_rdata    <= lfsr_q;
      // Redirection toward internal port; a full queue drops like buffer loss
      if (req_valid & redirect_to_cipher_flag)
      begin
        if (len_bad)
        begin
          size_drop_count <= size_drop_count + 16'h1;
          drop_pulse      <= 1'b1;
        end
        else if (!buf_space_ok || !f_in_ready)
        begin
          buffer_drop_count <= buffer_drop_count + 16'h1;
          drop_pulse        <= 1'b1;
        end
        else
        begin
          tx_port_valid  <= 1'b1;
          tx_egress_port <= `CF_CRYPTO_PORT;
        end
      end
      if (lfsr_wr)
        lfsr_q <= lfsr_wdata;
      case (state_q)
        ST_IDLE:
        begin
          if (f_valid)
          begin
            if (rsn != 3'h0)
            begin
              if (cfg_drop)
                drop_pulse <= 1'b1;
              else
              begin
                to_cpu_pulse <= 1'b1;
                cpu_reason   <= rsn;
              end
            end
            else
            begin
              reinject_valid       <= 1'b1;
              reinject_second_pass <= 1'b1;
              reinject_src_port    <= o_sp;
              reinject_dest_ports  <= o_dp;
              reinject_queue       <= o_q;
              reinject_defer_queue <= o_defer & (o_op == `CF_OP_DEC);
              hdr_vlan_skip        <= (o_pr == `CF_PROTO_MACSEC) ? cfg_macsec_vlans : 2'h0;
              if (o_op == `CF_OP_ENC)
              begin
                hdr_insert         <= o_pr;
                hdr_remove         <= 2'h3;
                hdr_ipv4_csum      <= o_v4 & (o_pr != `CF_PROTO_MACSEC);
                hdr_restore_l4     <= 1'b0;
                encrypted_flag     <= 1'b1;
                encrypted_sa_index <= o_sa;
                seq_q[o_sa]        <= hi + 32'h1;
                if (o_pr != `CF_PROTO_MACSEC)
                begin
                  iv_value <= lfsr_q;
                  if (!lfsr_wr)
                    lfsr_q <= {lfsr_q[30:0], ^(lfsr_q & `CF_LFSR_TAPS)};
                end
              end
              else
              begin
                hdr_insert         <= 2'h3;
                hdr_remove         <= o_pr;
                hdr_ipv4_csum      <= o_v4 & (o_pr != `CF_PROTO_MACSEC);
                hdr_restore_l4     <= (o_pr != `CF_PROTO_MACSEC);
                encrypted_flag     <= 1'b0;
                encrypted_sa_index <= o_sa;
                if (o_seq > hi)
                begin
                  seq_q[o_sa] <= o_seq;
                  seen_q[o_sa] <= (diff[31:7] == 25'h0 && (o_seq - hi) < 32'h80) ?
                    ((bm << (o_seq - hi)) | 128'h1) : 128'h1;
                end
                else
                  seen_q[o_sa] <= bm | (128'h1 << diff[6:0]);
              end
              state_q <= ST_SEND;
            end
          end
        end
        ST_SEND:
        begin
          if (reinject_ready)
          begin
            reinject_valid       <= 1'b0;
            reinject_second_pass <= 1'b0;
            state_q              <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // packet_crypto_port_flow
`default_nettype wire

// *** reinject_sink.sv ***
// Far-side consumer of re-injected packets, with random and commanded stalls
`timescale 1ns/10ps
`default_nettype none
module reinject_sink (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic stall,
  input  wire logic reinject_valid,
  output var logic  reinject_ready
);
  // Random gaps model a slow pipeline; stall lets the bench back up three requests in the FIFO
  initial reinject_ready = 1'b0;
  always @(posedge mclk)
  begin
    #2;
    reinject_ready = rstn && !stall && reinject_valid && ($urandom_range(2) != 0);
  end
endmodule // reinject_sink
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the crypto port packet flow block
`timescale 1ns/10ps
`default_nettype none
`include "crypto_flow_defines.vh"
module tb_top;
  logic        mclk, rstn, ce, req_valid, redirect_to_cipher_flag, from_acl, lfsr_wr, stall;
  logic        cipher_operation_select, is_ipv4, is_fragment, sa_hit, buf_space_ok, cfg_drop;
  logic        queue_fields_encrypted, icv_fail;
  logic [1:0]  encap_protocol_select, ipsec_table_protocol, cfg_macsec_vlans, k;
  logic [3:0]  security_assoc_index, src_port;
  logic [2:0]  dest_queue;
  logic [10:0] dest_ports;
  logic [14:0] pkt_len;
  logic [31:0] seq_num, cfg_macsec_window, lfsr_wdata, e;
  wire         tx_port_valid, reinject_valid, reinject_defer_queue, reinject_second_pass;
  wire         encrypted_flag, hdr_ipv4_csum, hdr_restore_l4, drop_pulse, to_cpu_pulse;
  wire         reinject_ready;
  wire [3:0]   tx_egress_port, reinject_src_port, encrypted_sa_index;
  wire [10:0]  reinject_dest_ports;
  wire [2:0]   reinject_queue, cpu_reason;
  wire [1:0]   hdr_insert, hdr_remove, hdr_vlan_skip;
  wire [31:0]  iv_value, lfsr_rdata;
  wire [15:0]  size_drop_count, buffer_drop_count;
  int          n_mismatch, samples_checked, cyc;
  logic [31:0] q[$];
  logic [31:0] dseq [7] = '{32'hc8, 32'hc8, 32'h48, 32'h49, 32'h32, 32'h27, 32'h28};
  logic [14:0] lens [4] = '{15'h003b, 15'h003c, 15'h4003, 15'h4004};
  packet_crypto_port_flow uut (.mclk, .rstn, .ce, .req_valid, .redirect_to_cipher_flag,
    .from_acl, .security_assoc_index, .cipher_operation_select, .encap_protocol_select,
    .ipsec_table_protocol, .dest_queue, .dest_ports, .src_port, .pkt_len, .is_ipv4,
    .is_fragment, .sa_hit, .queue_fields_encrypted, .buf_space_ok, .seq_num, .cfg_drop,
    .cfg_macsec_vlans, .cfg_macsec_window, .lfsr_wr, .lfsr_wdata, .icv_fail,
    .reinject_ready, .tx_port_valid, .tx_egress_port, .reinject_valid, .reinject_src_port,
    .reinject_dest_ports, .reinject_queue, .reinject_defer_queue, .reinject_second_pass,
    .encrypted_flag, .encrypted_sa_index, .hdr_insert, .hdr_remove, .hdr_vlan_skip,
    .hdr_ipv4_csum, .hdr_restore_l4, .iv_value, .lfsr_rdata, .drop_pulse, .to_cpu_pulse,
    .cpu_reason, .size_drop_count, .buffer_drop_count);
  reinject_sink sink (.mclk, .rstn, .stall, .reinject_valid, .reinject_ready);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task complete_run;
  begin
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task bad(input string m);
  begin
    $display("wrong value at %0t: %s", $time, m);
    n_mismatch++;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  task idle;
  begin
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    redirect_to_cipher_flag = 1'b0;
    while (q.size() != 0) @(posedge mclk);
    #1;
  end
  endtask
  // Notes hold the outcome kind, reason, context, header codes, operation and index
  task issue(input logic op, input logic [1:0] pr, input logic [3:0] sa,
    input logic [14:0] len, input logic [31:0] sq, input logic [2:0] fl,
    input logic [1:0] kd, input logic [2:0] rs, input logic b2b);
  begin
    @(posedge mclk);
    #1;
    {src_port, dest_ports, dest_queue, from_acl} = $urandom;
    req_valid = 1'b1;
    redirect_to_cipher_flag = 1'b1;
    security_assoc_index = sa;
    cipher_operation_select = op;
    queue_fields_encrypted = op;
    encap_protocol_select = from_acl ? pr : ~pr;
    ipsec_table_protocol = from_acl ? ~pr : pr;
    {pkt_len, seq_num, buf_space_ok, is_fragment, sa_hit} = {len, sq, fl};
    q.push_back(kd != 2'h0 ? {kd, rs, 27'h0} : {kd, 3'h0, src_port, dest_ports, dest_queue,
      op ? 2'h3 : pr, op ? pr : 2'h3, op, sa});
    if (!b2b)
      idle;
  end
  endtask
  always @(negedge mclk)
    if (rstn && (drop_pulse || to_cpu_pulse || (reinject_valid && reinject_ready)))
    begin
      k = drop_pulse ? 2'h1 : (to_cpu_pulse ? 2'h2 : 2'h0);
      if (q.size() == 0)
        bad("result without request");
      else
      begin
        e = q.pop_front();
        samples_checked++;
        if (e[31:30] !== k) bad("outcome kind");
        else if (k == 2'h2 && cpu_reason !== e[29:27]) bad("cpu reason");
        else if (k == 2'h0 && {reinject_src_port, reinject_dest_ports, reinject_queue}
          !== e[26:9]) bad("reinject context");
        else if (k == 2'h0 && {hdr_insert, hdr_remove} !== e[8:5])
          bad("header edit");
        else if (k == 2'h0 && e[8:7] == `CF_PROTO_MACSEC && hdr_vlan_skip !== cfg_macsec_vlans)
          bad("vlan placement");
        else if (k == 2'h0 && encrypted_flag !== ~e[4]) bad("encrypted flag");
        else if (k == 2'h0 && !e[4] && encrypted_sa_index !== e[3:0]) bad("sa index");
        else if (k == 2'h0 && reinject_defer_queue !== e[4]) bad("defer queue");
        else if (k == 2'h0 && hdr_ipv4_csum !== ((e[4] ? e[6:5] : e[8:7]) != `CF_PROTO_MACSEC))
          bad("ipv4 checksum");
        else if (k == 2'h0 && hdr_restore_l4 !== (e[4] && e[6:5] != `CF_PROTO_MACSEC))
          bad("l4 restore");
      end
    end
  initial
  begin
    {req_valid, redirect_to_cipher_flag, from_acl, cipher_operation_select, is_fragment} = 5'h0;
    {sa_hit, buf_space_ok, cfg_drop, lfsr_wr, icv_fail, stall, queue_fields_encrypted} = 7'h0;
    {encap_protocol_select, ipsec_table_protocol, security_assoc_index, src_port} = 12'h0;
    {dest_queue, dest_ports, pkt_len, seq_num, lfsr_wdata} = 93'h0;
    {ce, is_ipv4, cfg_macsec_vlans, cfg_macsec_window} = {2'h3, 2'h2, 32'h0000_000a};
    {rstn, n_mismatch, samples_checked, cyc} = 0;
    e = $urandom(32'hedb3);
    repeat (8) @(posedge mclk);
    #1 rstn = 1'b1;
    @(posedge mclk);
    #1 {lfsr_wr, lfsr_wdata} = {1'b1, $urandom};
    @(posedge mclk);
    #1 lfsr_wr = 1'b0;
    repeat (2) @(posedge mclk);
    #1 samples_checked++;
    if (lfsr_rdata !== lfsr_wdata) bad("lfsr readback");
    for (int i = 0; i < 4; i++)
      issue(1'b0, `CF_PROTO_ESP, 4'h1, lens[i], 32'h0, 3'b101, (i % 3 == 0) ? 2'h1 : 2'h0,
        3'h0, 1'b0);
    issue(1'b0, `CF_PROTO_ESP, 4'h1, 15'h0100, 32'h0, 3'b001, 2'h1, 3'h0, 1'b0);
    for (int p = 0; p < 3; p++)
      issue(1'b0, p[1:0], 4'h1, 15'h0100, 32'h0, 3'b101, 2'h0, 3'h0, 1'b0);
    // Second and third IPSec and middle MACsec entries break the replay windows
    for (int i = 0; i < 7; i++)
      issue(1'b1, (i < 4) ? `CF_PROTO_ESP : `CF_PROTO_MACSEC, (i < 4) ? 4'h2 : 4'h3, 15'h0100,
        dseq[i], 3'b101, (i == 1 || i == 2 || i == 5) ? 2'h2 : 2'h0,
        (i == 1 || i == 2 || i == 5) ? `CF_RSN_REPLAY : 3'h0, 1'b0);
    cfg_drop = 1'b1;
    issue(1'b1, `CF_PROTO_ESP, 4'h2, 15'h0100, 32'h49, 3'b101, 2'h1, 3'h0, 1'b0);
    cfg_drop = 1'b0;
    issue(1'b1, `CF_PROTO_ESP, 4'h5, 15'h0100, 32'h1, 3'b111, 2'h2, `CF_RSN_FRAG, 1'b0);
    issue(1'b1, `CF_PROTO_ESP, 4'h6, 15'h0100, 32'h1, 3'b100, 2'h2, `CF_RSN_NO_SA, 1'b0);
    stall = 1'b1;
    repeat (`CF_FIFO_DEPTH)
      issue(1'b0, `CF_PROTO_AH, 4'h1, 15'h0080, 32'h0, 3'b101, 2'h0, 3'h0, 1'b1);
    fork
      #100 stall = 1'b0;
      idle;
    join
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
